// [hw/sfcc_defines.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef SFCC_DEFINES_SVH
`define SFCC_DEFINES_SVH
// Device register map (7-bit serial addresses)
`define SFCC_ADDR_OPMODE 7'h01
`define SFCC_ADDR_FRF_MSB 7'h07
`define SFCC_ADDR_FRF_MID 7'h08
`define SFCC_ADDR_FRF_LSB 7'h09
`define SFCC_ADDR_PIN_MAP1 7'h25
`define SFCC_ADDR_PIN_MAP2 7'h26
`define SFCC_ADDR_FLAGS 7'h27
`define SFCC_OPMODE_RST 8'h04
`define SFCC_FRF_RST 24'h000000
`define SFCC_PIN_MAP1_RST 8'h00
`define SFCC_PIN_MAP2_RST 8'h00
`define SFCC_OPMODE_SEQ_OFF 7
`define SFCC_FLAG_XO_READY 7
`define SFCC_FLAG_PLL_LOCK 4
// Clock-output select: 0..max picks divider tap, off code stops the pin
`define SFCC_CLKSEL_DIV_MAX 3'h5
`define SFCC_CLKSEL_OFF 3'h7
// Synthesizer resolution
`define SFCC_SYNTH_FRAC_BITS 19
// Controller register map (AXI4-Lite byte addresses)
`define SFCC_AXI_CMD 8'h00
`define SFCC_AXI_STATUS 8'h04
`define SFCC_AXI_IRQ_STATUS 8'h08
`define SFCC_AXI_IRQ_CLEAR 8'h0c
`define SFCC_AXI_IRQ_ENABLE 8'h10
`define SFCC_IRQ_DONE 0
`define SFCC_IRQ_CLOCK 1
`define SFCC_IRQ_LOCK 2
`define SFCC_IRQ_UNLOCK 3
`define SFCC_RESP_OKAY 2'h0
`define SFCC_RESP_SLVERR 2'h2
// Timing
`define SFCC_CLK_PERIOD_NS 40
`define SFCC_SCK_HALF_NS 50
`define SFCC_SCK_HALF_CYC ((`SFCC_SCK_HALF_NS + `SFCC_CLK_PERIOD_NS - 1) / `SFCC_CLK_PERIOD_NS)
`define SFCC_XO_STARTUP_US 500
`define SFCC_XO_STARTUP_CYC ((`SFCC_XO_STARTUP_US * 1000 + `SFCC_CLK_PERIOD_NS - 1) / `SFCC_CLK_PERIOD_NS)
`define SFCC_SYNTH_LOCK_US 150
`define SFCC_SYNTH_LOCK_CYC ((`SFCC_SYNTH_LOCK_US * 1000 + `SFCC_CLK_PERIOD_NS - 1) / `SFCC_CLK_PERIOD_NS)
`endif

// [hw/sfcc_device.sv]
// Device end: serial register port, carrier word, start-up sequencer, clock output
`timescale 1ns/10ps
`include "sfcc_defines.svh"
module sfcc_device (
	input wire logic aclk,
	input wire logic aresetn,
	sfcc_link_if.device link,
	input wire logic xo_ready,
	input wire logic pll_locked,
	output logic xo_enable,
	output logic pll_enable,
	output logic rx_enable,
	output logic tx_enable,
	output logic cal_coarse,
	output logic cal_fine,
	output logic [23:0] active_frf
);
	logic sck_q, next_sck_q;
	logic [4:0] bit_cnt, next_bit_cnt;
	logic [15:0] sh_in, next_sh_in;
	logic [7:0] miso_sh, next_miso_sh;
	logic miso, next_miso;
	logic miso_oe, next_miso_oe;
	logic [7:0] opmode, next_opmode;
	logic [7:0] frf_msb, next_frf_msb;
	logic [7:0] frf_mid, next_frf_mid;
	logic [7:0] carrier_low_byte, next_carrier_low_byte;
	logic [23:0] next_active_frf;
	logic [7:0] pin_map_first_reg, next_pin_map_first_reg;
	logic [7:0] pin_map_second_reg, next_pin_map_second_reg;
	logic [15:0] word;
	logic [7:0] sh_val;
	logic [7:0] rd_data;
	sfcc_pkg::sfcc_seq_type seq, next_seq;
	sfcc_pkg::sfcc_mode_type mode;
	logic seq_off, want_pll, want_radio;
	logic next_xo_enable, next_pll_enable, next_rx_enable, next_tx_enable;
	logic next_cal_coarse, next_cal_fine;
	logic por, next_por;
	logic [7:0] div_cnt, next_div_cnt;
	logic clk_pin, next_clk_pin;
	logic lock_a, next_lock_a, lock_b, next_lock_b;
	logic [2:0] clock_output_select;

	assign link.miso = miso;
	assign link.miso_oe = miso_oe;
	assign link.general_pin_five = clk_pin;
	assign link.lock_pin_a = lock_a;
	assign link.lock_pin_b = lock_b;
	assign clock_output_select = pin_map_second_reg[2:0];

	// Register read mux; the upper carrier bytes read back as programmed, not as active
	always_comb begin
		case (sh_in[6:0])
			`SFCC_ADDR_OPMODE: rd_data = opmode;
			`SFCC_ADDR_FRF_MSB: rd_data = frf_msb;
			`SFCC_ADDR_FRF_MID: rd_data = frf_mid;
			`SFCC_ADDR_FRF_LSB: rd_data = carrier_low_byte;
			`SFCC_ADDR_PIN_MAP1: rd_data = pin_map_first_reg;
			`SFCC_ADDR_PIN_MAP2: rd_data = pin_map_second_reg;
			`SFCC_ADDR_FLAGS: rd_data = {xo_ready, 2'h0, pll_locked, 4'h0};
			default: rd_data = 8'h00;
		endcase
	end

	// Serial slave: sample on SCK rise, shift out on SCK fall, one byte per frame
	always_comb begin
		word = {sh_in[14:0], link.mosi};
		sh_val = 8'h00;
		next_sck_q = link.sck;
		next_bit_cnt = bit_cnt;
		next_sh_in = sh_in;
		next_miso_sh = miso_sh;
		next_miso = miso;
		next_miso_oe = ~link.nss_n;
		next_opmode = opmode;
		next_frf_msb = frf_msb;
		next_frf_mid = frf_mid;
		next_carrier_low_byte = carrier_low_byte;
		next_active_frf = active_frf;
		next_pin_map_first_reg = pin_map_first_reg;
		next_pin_map_second_reg = pin_map_second_reg;
		if (link.nss_n) begin
			next_bit_cnt = 5'h00;
			next_miso = 1'b0;
		end else if (link.sck && !sck_q) begin
			next_sh_in = word;
			next_bit_cnt = bit_cnt + 5'h01;
			if (bit_cnt == 5'h0f && word[15]) begin
				case (word[14:8])
					`SFCC_ADDR_OPMODE: next_opmode = word[7:0];
					`SFCC_ADDR_FRF_MSB: next_frf_msb = word[7:0];
					`SFCC_ADDR_FRF_MID: next_frf_mid = word[7:0];
					`SFCC_ADDR_FRF_LSB: begin
						next_carrier_low_byte = word[7:0];
						next_active_frf = {frf_msb, frf_mid, word[7:0]};
					end
					`SFCC_ADDR_PIN_MAP1: next_pin_map_first_reg = word[7:0];
					`SFCC_ADDR_PIN_MAP2: next_pin_map_second_reg = word[7:0];
					default: ;
				endcase
			end
		end else if (!link.sck && sck_q && bit_cnt >= 5'h08) begin
			// First data bit must be out before the ninth rising edge
			sh_val = (bit_cnt == 5'h08) ? rd_data : {miso_sh[6:0], 1'b0};
			next_miso_sh = sh_val;
			next_miso = sh_val[7];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sck_q <= 1'b0;
			bit_cnt <= 5'h00;
			sh_in <= 16'h0000;
			miso_sh <= 8'h00;
			miso <= 1'b0;
			miso_oe <= 1'b0;
			opmode <= `SFCC_OPMODE_RST;
			frf_msb <= 8'(`SFCC_FRF_RST >> 16);
			frf_mid <= 8'(`SFCC_FRF_RST >> 8);
			carrier_low_byte <= 8'(`SFCC_FRF_RST);
			active_frf <= `SFCC_FRF_RST;
			pin_map_first_reg <= `SFCC_PIN_MAP1_RST;
			pin_map_second_reg <= `SFCC_PIN_MAP2_RST;
		end else begin
			sck_q <= next_sck_q;
			bit_cnt <= next_bit_cnt;
			sh_in <= next_sh_in;
			miso_sh <= next_miso_sh;
			miso <= next_miso;
			miso_oe <= next_miso_oe;
			opmode <= next_opmode;
			frf_msb <= next_frf_msb;
			frf_mid <= next_frf_mid;
			carrier_low_byte <= next_carrier_low_byte;
			active_frf <= next_active_frf;
			pin_map_first_reg <= next_pin_map_first_reg;
			pin_map_second_reg <= next_pin_map_second_reg;
		end
	end

	assign mode = sfcc_pkg::sfcc_mode_type'(opmode[4:2]);
	assign seq_off = opmode[`SFCC_OPMODE_SEQ_OFF];
	assign want_radio = (mode == sfcc_pkg::MODE_TX) || (mode == sfcc_pkg::MODE_RX);
	assign want_pll = want_radio || (mode == sfcc_pkg::MODE_FS);

	// Start-up sequencer, calibration strobes, clock output and lock routing
	always_comb begin
		next_seq = seq;
		unique case (seq)
			sfcc_pkg::SEQ_OFF: if (mode != sfcc_pkg::MODE_SLEEP) next_seq = sfcc_pkg::SEQ_XO;
			sfcc_pkg::SEQ_XO: if (xo_ready && want_pll) next_seq = sfcc_pkg::SEQ_PLL;
			sfcc_pkg::SEQ_PLL: begin
				if (!want_pll) next_seq = sfcc_pkg::SEQ_XO;
				else if (pll_locked && want_radio) next_seq = sfcc_pkg::SEQ_RUN;
			end
			sfcc_pkg::SEQ_RUN: begin
				if (!want_pll) next_seq = sfcc_pkg::SEQ_XO;
				else if (!want_radio) next_seq = sfcc_pkg::SEQ_PLL;
			end
		endcase
		if (mode == sfcc_pkg::MODE_SLEEP) next_seq = sfcc_pkg::SEQ_OFF;
		// With the sequencer off the mode drives the blocks straight; host does the waiting
		if (seq_off) begin
			next_xo_enable = mode != sfcc_pkg::MODE_SLEEP;
			next_pll_enable = want_pll;
			next_tx_enable = mode == sfcc_pkg::MODE_TX;
			next_rx_enable = mode == sfcc_pkg::MODE_RX;
		end else begin
			next_xo_enable = next_seq != sfcc_pkg::SEQ_OFF;
			next_pll_enable = (next_seq == sfcc_pkg::SEQ_PLL) || (next_seq == sfcc_pkg::SEQ_RUN);
			next_tx_enable = (next_seq == sfcc_pkg::SEQ_RUN) && (mode == sfcc_pkg::MODE_TX);
			next_rx_enable = (next_seq == sfcc_pkg::SEQ_RUN) && (mode == sfcc_pkg::MODE_RX);
		end
		next_cal_fine = next_pll_enable && !pll_enable;
		next_cal_coarse = por;
		next_por = 1'b0;
		next_div_cnt = div_cnt + 8'h01;
		// Tap 0 toggles each cycle; the pin stays low until the crystal is stable
		next_clk_pin = xo_ready && (mode != sfcc_pkg::MODE_SLEEP)
			&& (clock_output_select <= `SFCC_CLKSEL_DIV_MAX)
			&& div_cnt[clock_output_select];
		next_lock_a = pin_map_first_reg[0] && pll_locked;
		next_lock_b = pin_map_first_reg[1] && pll_locked;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seq <= sfcc_pkg::SEQ_OFF;
			xo_enable <= 1'b0;
			pll_enable <= 1'b0;
			rx_enable <= 1'b0;
			tx_enable <= 1'b0;
			cal_coarse <= 1'b0;
			cal_fine <= 1'b0;
			por <= 1'b1;
			div_cnt <= 8'h00;
			clk_pin <= 1'b0;
			lock_a <= 1'b0;
			lock_b <= 1'b0;
		end else begin
			seq <= next_seq;
			xo_enable <= next_xo_enable;
			pll_enable <= next_pll_enable;
			rx_enable <= next_rx_enable;
			tx_enable <= next_tx_enable;
			cal_coarse <= next_cal_coarse;
			cal_fine <= next_cal_fine;
			por <= next_por;
			div_cnt <= next_div_cnt;
			clk_pin <= next_clk_pin;
			lock_a <= next_lock_a;
			lock_b <= next_lock_b;
		end
	end
endmodule

// [hw/sfcc_host.sv]
// Controller end: AXI4-Lite registers, serial master, clock and lock watch
`timescale 1ns/10ps
`include "sfcc_defines.svh"
module sfcc_host #(
	parameter int unsigned XO_WAIT_CYC = `SFCC_XO_STARTUP_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	sfcc_link_if.host link,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic irq
);
	logic aw_full, next_aw_full, w_full, next_w_full;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic [1:0] next_bresp, next_rresp;
	logic next_bvalid, next_rvalid;
	logic [31:0] next_rdata;
	logic [3:0] irq_status, next_irq_status, irq_enable, next_irq_enable, clr, events;
	logic do_wr, start, busy;
	sfcc_pkg::sfcc_spi_type st, next_st;
	logic nss_n, next_nss_n, sck, next_sck, mosi, next_mosi;
	logic [15:0] sh_out, next_sh_out;
	logic [7:0] sh_in, next_sh_in, rd_byte, next_rd_byte;
	logic [1:0] half_cnt, next_half_cnt;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic clk_q, next_clk_q, clk_seen, next_clk_seen;
	logic lock_q, next_lock_q, locked, next_locked;
	logic [15:0] wait_cnt, next_wait_cnt, low_cnt, next_low_cnt;
	logic lock_now, done_ev;

	assign link.nss_n = nss_n;
	assign link.sck = sck;
	assign link.mosi = mosi;
	assign awready = ~aw_full;
	assign wready = ~w_full;
	assign arready = ~rvalid;
	assign busy = st != sfcc_pkg::SPI_IDLE;
	assign do_wr = aw_full && w_full && !bvalid;
	assign irq = |(irq_status & irq_enable);
	assign lock_now = link.lock_pin_a | link.lock_pin_b;

	// Bus slave, command launch and sticky interrupt flags
	always_comb begin
		next_aw_full = aw_full;
		next_aw_addr = aw_addr;
		next_w_full = w_full;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		next_irq_enable = irq_enable;
		clr = 4'h0;
		start = 1'b0;
		if (awvalid && !aw_full) begin
			next_aw_full = 1'b1;
			next_aw_addr = awaddr;
		end
		if (wvalid && !w_full) begin
			next_w_full = 1'b1;
			next_w_data = wdata;
			next_w_strb = wstrb;
		end
		if (bvalid && bready) next_bvalid = 1'b0;
		if (do_wr) begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = `SFCC_RESP_OKAY;
			case (aw_addr)
				// A command while a frame runs is dropped; software polls busy first
				`SFCC_AXI_CMD: start = (w_strb[1:0] == 2'h3) && !busy;
				`SFCC_AXI_IRQ_CLEAR: clr = w_strb[0] ? w_data[3:0] : 4'h0;
				`SFCC_AXI_IRQ_ENABLE: if (w_strb[0]) next_irq_enable = w_data[3:0];
				default: next_bresp = `SFCC_RESP_SLVERR;
			endcase
		end
		if (rvalid && rready) next_rvalid = 1'b0;
		if (arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			next_rresp = `SFCC_RESP_OKAY;
			case (araddr)
				`SFCC_AXI_CMD: next_rdata = {16'h0000, sh_out};
				`SFCC_AXI_STATUS: next_rdata = {16'h0000, rd_byte, 4'h0, locked, clk_seen, lock_now, busy};
				`SFCC_AXI_IRQ_STATUS: next_rdata = {28'h0000000, irq_status};
				`SFCC_AXI_IRQ_CLEAR: next_rdata = 32'h00000000;
				`SFCC_AXI_IRQ_ENABLE: next_rdata = {28'h0000000, irq_enable};
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = `SFCC_RESP_SLVERR;
				end
			endcase
		end
		// A new event wins over a clear in the same cycle
		next_irq_status = (irq_status & ~clr) | events;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			aw_addr <= 8'h00;
			w_full <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= 2'h0;
			irq_status <= 4'h0;
			irq_enable <= 4'h0;
		end else begin
			aw_full <= next_aw_full;
			aw_addr <= next_aw_addr;
			w_full <= next_w_full;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			irq_status <= next_irq_status;
			irq_enable <= next_irq_enable;
		end
	end

	// Serial master: 16-bit frame, data changes on SCK fall, MISO sampled on rise
	always_comb begin
		next_st = st;
		next_nss_n = nss_n;
		next_sck = sck;
		next_mosi = mosi;
		next_sh_out = sh_out;
		next_sh_in = sh_in;
		next_rd_byte = rd_byte;
		next_bit_cnt = bit_cnt;
		next_half_cnt = half_cnt + 2'h1;
		done_ev = 1'b0;
		unique case (st)
			sfcc_pkg::SPI_IDLE: begin
				next_half_cnt = 2'h0;
				if (start) begin
					next_st = sfcc_pkg::SPI_SHIFT;
					next_nss_n = 1'b0;
					next_sh_out = w_data[15:0];
					next_mosi = w_data[15];
					next_bit_cnt = 4'h0;
				end
			end
			sfcc_pkg::SPI_SHIFT: if (half_cnt == 2'(`SFCC_SCK_HALF_CYC - 1)) begin
				next_half_cnt = 2'h0;
				next_sck = !sck;
				if (!sck) next_sh_in = {sh_in[6:0], link.miso_line};
				else if (bit_cnt == 4'hf) next_st = sfcc_pkg::SPI_END;
				else begin
					next_bit_cnt = bit_cnt + 4'h1;
					next_sh_out = {sh_out[14:0], 1'b0};
					next_mosi = sh_out[14];
				end
			end
			// Hold select low one half period past the last fall
			sfcc_pkg::SPI_END: if (half_cnt == 2'(`SFCC_SCK_HALF_CYC - 1)) begin
				next_st = sfcc_pkg::SPI_IDLE;
				next_nss_n = 1'b1;
				next_rd_byte = sh_in;
				done_ev = 1'b1;
			end
			default: next_st = sfcc_pkg::SPI_IDLE;
		endcase
	end

	// Crystal-ready and lock watch
	always_comb begin
		next_clk_q = link.general_pin_five;
		next_lock_q = lock_now;
		next_clk_seen = clk_seen;
		next_locked = locked;
		next_wait_cnt = wait_cnt;
		next_low_cnt = 16'h0000;
		events = {3'h0, done_ev};
		if (!clk_seen) begin
			next_wait_cnt = wait_cnt + 16'h0001;
			// Either a clock edge or the worst-case start-up time ends the wait
			if ((link.general_pin_five != clk_q) || (32'(wait_cnt) >= XO_WAIT_CYC - 1)) begin
				next_clk_seen = 1'b1;
				events[`SFCC_IRQ_CLOCK] = 1'b1;
			end
		end
		if (lock_now && !lock_q && !locked) begin
			next_locked = 1'b1;
			events[`SFCC_IRQ_LOCK] = 1'b1;
		end
		// Modulation can blip the indicator; only a drop lasting the whole lock time counts
		if (locked && !lock_now) begin
			next_low_cnt = low_cnt + 16'h0001;
			if (low_cnt == 16'(`SFCC_SYNTH_LOCK_CYC - 1)) begin
				next_locked = 1'b0;
				events[`SFCC_IRQ_UNLOCK] = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= sfcc_pkg::SPI_IDLE;
			nss_n <= 1'b1;
			sck <= 1'b0;
			mosi <= 1'b0;
			sh_out <= 16'h0000;
			sh_in <= 8'h00;
			rd_byte <= 8'h00;
			half_cnt <= 2'h0;
			bit_cnt <= 4'h0;
			clk_q <= 1'b0;
			lock_q <= 1'b0;
			clk_seen <= 1'b0;
			locked <= 1'b0;
			wait_cnt <= 16'h0000;
			low_cnt <= 16'h0000;
		end else begin
			st <= next_st;
			nss_n <= next_nss_n;
			sck <= next_sck;
			mosi <= next_mosi;
			sh_out <= next_sh_out;
			sh_in <= next_sh_in;
			rd_byte <= next_rd_byte;
			half_cnt <= next_half_cnt;
			bit_cnt <= next_bit_cnt;
			clk_q <= next_clk_q;
			lock_q <= next_lock_q;
			clk_seen <= next_clk_seen;
			locked <= next_locked;
			wait_cnt <= next_wait_cnt;
			low_cnt <= next_low_cnt;
		end
	end
endmodule

// [hw/sfcc_link_if.sv]
// Serial register port and general pins between controller and device
`timescale 1ns/10ps
interface sfcc_link_if;
	logic nss_n;
	logic sck;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic miso_line;
	logic general_pin_five;
	logic lock_pin_a;
	logic lock_pin_b;
	// Undriven data line reads low
	assign miso_line = miso_oe & miso;
	modport device(input nss_n, input sck, input mosi, output miso, output miso_oe,
		output general_pin_five, output lock_pin_a, output lock_pin_b);
	modport host(output nss_n, output sck, output mosi, input miso_line,
		input general_pin_five, input lock_pin_a, input lock_pin_b);
endinterface

// [hw/sfcc_pkg.sv]
// Shared types of the synthesizer control block
package sfcc_pkg;
	typedef enum logic [2:0] {
		MODE_SLEEP = 3'b000,
		MODE_STBY = 3'b001,
		MODE_FS = 3'b010,
		MODE_TX = 3'b011,
		MODE_RX = 3'b100
	} sfcc_mode_type;
	typedef enum logic [1:0] {
		SEQ_OFF = 2'b00,
		SEQ_XO = 2'b01,
		SEQ_PLL = 2'b10,
		SEQ_RUN = 2'b11
	} sfcc_seq_type;
	typedef enum logic [1:0] {
		SPI_IDLE = 2'b00,
		SPI_SHIFT = 2'b01,
		SPI_END = 2'b10
	} sfcc_spi_type;
endpackage

// [sim/sfcc_link_sva.sv]
// Checker for the link between controller and device, with device user side
`timescale 1ns/10ps
module sfcc_link_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic nss_n,
	input wire logic sck,
	input wire logic miso_line,
	input wire logic general_pin_five,
	input wire logic lock_pin_a,
	input wire logic lock_pin_b,
	input wire logic xo_ready,
	input wire logic pll_locked,
	input wire logic pll_enable,
	input wire logic rx_enable,
	input wire logic cal_fine,
	input wire logic cal_coarse
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Pin may lag the crystal flag, so allow a short settle
	clk_gate_a: assert property (!xo_ready [*3] |-> !general_pin_five)
		else $error("clock pin active without stable crystal");
	lock_route_a: assert property ((lock_pin_a || lock_pin_b) |-> $past(pll_locked))
		else $error("lock pin high without lock");
	pll_start_a: assert property ($rose(pll_enable) |-> $past(xo_ready))
		else $error("pll started before crystal stable");
	fine_cal_a: assert property ($rose(pll_enable) |-> ##[0:1] cal_fine)
		else $error("no fine calibration on pll start");
	fine_pulse_a: assert property (cal_fine |=> !cal_fine)
		else $error("fine calibration pulse too long");
	coarse_cal_a: assert property ($rose(aresetn) |-> ##[0:2] cal_coarse)
		else $error("no coarse calibration after reset");
	radio_start_a: assert property ($rose(rx_enable) |-> $past(pll_locked) && pll_enable)
		else $error("receiver started before lock");
	radio_lock_a: assert property (!pll_locked [*3] |-> !$rose(rx_enable))
		else $error("receiver rose while unlocked");
	frame_sck_a: assert property ($rose(sck) |-> !nss_n)
		else $error("serial clock outside frame");
	line_idle_a: assert property (nss_n [*2] |-> !miso_line)
		else $error("data line driven while deselected");
	frame_c: cover property ($fell(nss_n));
	lock_c: cover property ($rose(lock_pin_a));
	radio_c: cover property ($rose(rx_enable));
endmodule

// [sim/synth_freq_and_clock_out_ctrl_tb.sv]
// Bench joining controller and device across the link interface
`timescale 1ns/10ps
module synth_freq_and_clock_out_ctrl_tb;
	typedef struct packed {logic [6:0] a; logic [7:0] d; logic [23:0] f;} sfcc_row_type;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, xo_ready, pll_locked;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, bs, rs;
	logic xo_enable, pll_enable, rx_enable, tx_enable, cal_coarse, cal_fine;
	logic [23:0] active_frf;
	int fail_count, comparisons, p;
	// Upper bytes alone must leave the active word alone
	sfcc_row_type rows [5] = '{'{7'h07, 8'h12, 24'h0}, '{7'h08, 8'h34, 24'h0},
		'{7'h09, 8'h56, 24'h123456}, '{7'h07, 8'hab, 24'h123456}, '{7'h25, 8'h01, 24'h123456}};
	sfcc_link_if lnk();
	sfcc_device i_sfcc_device (.aclk(aclk), .aresetn(aresetn), .link(lnk.device),
		.xo_ready(xo_ready), .pll_locked(pll_locked), .xo_enable(xo_enable),
		.pll_enable(pll_enable), .rx_enable(rx_enable), .tx_enable(tx_enable),
		.cal_coarse(cal_coarse), .cal_fine(cal_fine), .active_frf(active_frf));
	// Short crystal wait keeps the timeout path inside the run
	sfcc_host #(.XO_WAIT_CYC(20)) i_sfcc_host (.aclk(aclk), .aresetn(aresetn), .link(lnk.host),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .irq(irq));
	sfcc_link_sva u_sva (.aclk(aclk), .aresetn(aresetn), .nss_n(lnk.nss_n), .sck(lnk.sck),
		.miso_line(lnk.miso_line), .general_pin_five(lnk.general_pin_five),
		.lock_pin_a(lnk.lock_pin_a), .lock_pin_b(lnk.lock_pin_b), .xo_ready(xo_ready),
		.pll_locked(pll_locked), .pll_enable(pll_enable), .rx_enable(rx_enable),
		.cal_fine(cal_fine), .cal_coarse(cal_coarse));
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (e !== s) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task close_out;
		$display("mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task wt(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Each channel is released at the edge that takes it; bready waits for the answer
	// No wait limit here: only the watchdog ends a hung handshake
	task axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bs = bresp;
		bready <= 1'b0;
	endtask
	task axr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	// One serial frame, then poll busy; the last poll carries the read byte
	task dev(input logic wr, input logic [6:0] a, input logic [7:0] d);
		axw(8'h00, {16'h0000, wr, a, d});
		do begin
			axr(8'h04);
		end while (rd[0] !== 1'b0);
	endtask
	// Cycles between two rises of the clock pin, 0 when it stays still
	task per(output int pr);
		int c, r;
		logic l;
		r = 0;
		pr = 0;
		l = 1'b1;
		for (c = 0; c < 200 && r < 2; c++) begin
			@(posedge aclk);
			if (lnk.general_pin_five === 1'b1 && l === 1'b0) begin
				r++;
				pr = (r == 1) ? c : c - pr;
			end
			l = lnk.general_pin_five;
		end
		if (r < 2) pr = 0;
	endtask
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	initial begin
		#(40 * 40000);
		fail_count++;
		close_out;
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, xo_ready, pll_locked} = 8'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		fail_count = 0;
		comparisons = 0;
		wt(2);
		aresetn <= 1'b1;
		wt(3);
		chk("xo_enable", 1, xo_enable);
		per(p);
		chk("pin before crystal", 0, p);
		xo_ready <= 1'b1;
		per(p);
		chk("pin after reset", 2, p);
		axr(8'h08);
		chk("clock seen", 1, rd[1]);
		$display("reset test done");
		foreach (rows[i]) begin
			dev(1'b1, rows[i].a, rows[i].d);
			chk("active_frf", rows[i].f, active_frf);
			dev(1'b0, rows[i].a, 8'h00);
			chk("readback", rows[i].d, rd[15:8]);
		end
		$display("register rows done");
		for (int k = 0; k < 8; k++) begin
			dev(1'b1, 7'h26, 8'(k));
			per(p);
			chk("clock period", (k <= 5) ? (1 << (k + 1)) : 0, p);
		end
		dev(1'b1, 7'h26, 8'h00);
		$display("clock select done");
		axw(8'h10, 32'h4);
		dev(1'b1, 7'h01, 8'h10);
		wt(5);
		chk("pll_enable", 1, pll_enable);
		chk("rx early", 0, rx_enable);
		pll_locked <= 1'b1;
		wt(5);
		chk("rx_enable", 1, rx_enable);
		chk("lock pin", 1, lnk.lock_pin_a);
		chk("irq lock", 1, irq);
		axw(8'h0c, 32'h4);
		wt(2);
		chk("irq cleared", 0, irq);
		pll_locked <= 1'b0;
		wt(10);
		pll_locked <= 1'b1;
		axr(8'h08);
		chk("short drop", 0, rd[3]);
		pll_locked <= 1'b0;
		wt(3800);
		axr(8'h08);
		chk("lock lost", 1, rd[3]);
		pll_locked <= 1'b1;
		axw(8'h10, 32'h0);
		wt(2);
		chk("irq masked", 0, irq);
		// Locked receiver switched to transmit stays running
		dev(1'b1, 7'h01, 8'h0c);
		wt(3);
		chk("tx_enable", 1, tx_enable);
		chk("rx after tx", 0, rx_enable);
		// Sequencer off: the mode drives the blocks straight
		dev(1'b1, 7'h01, 8'h88);
		wt(3);
		chk("manual pll", 1, pll_enable);
		chk("manual tx", 0, tx_enable);
		$display("sequencer and lock done");
		dev(1'b1, 7'h01, 8'h00);
		per(p);
		chk("pin in sleep", 0, p);
		// Clock output switched off when unneeded; reset must bring it back
		dev(1'b1, 7'h26, 8'h07);
		axw(8'h14, 32'h0);
		chk("bad write", 2, bs);
		axr(8'h14);
		chk("bad read", 2, rs);
		$display("sleep and unmapped done");
		aresetn <= 1'b0;
		wt(2);
		aresetn <= 1'b1;
		wt(3);
		chk("frf after reset", 0, active_frf);
		per(p);
		chk("pin after second reset", 2, p);
		$display("second reset done");
		close_out;
	end
endmodule
